// ---- hdl/ccs_ctx_switch.sv ----
// Channel scheduler with context save and reload, plus engine result FIFO
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module ccs_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Drain side
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("ccs_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic [AW:0]      cnt_nxt;
    logic             ready_r;
    wire              push = in_valid && ready_r;
    wire              pop  = out_valid && out_ready;

    assign cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready  = ready_r;
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem[rp_r];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wp_r    <= '0;
            rp_r    <= '0;
            cnt_r   <= '0;
            ready_r <= 1'b0;
        end else begin
            wp_r    <= wp_r + AW'(push);
            rp_r    <= rp_r + AW'(pop);
            cnt_r   <= cnt_nxt;
            ready_r <= (cnt_nxt != (AW+1)'(DEPTH));
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module ccs_ctx_switch
    import ccs_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    // Channel control
    input  wire logic [31:0]          ctx_base,
    input  wire logic [CCS_NCH-1:0]   chan_start,
    input  wire logic [31:0]          chan_ptr,
    output logic      [CCS_NCH-1:0]   chan_busy,
    // Memory master
    output ccs_mreq_t                 mem_o,
    input  wire logic                 mem_ack,
    input  wire logic [31:0]          mem_rdata,
    // Engine
    output logic                      eng_go,
    output logic      [1:0]           eng_chan,
    output logic      [31:0]          eng_ctrl,
    output logic      [9:0][31:0]     eng_ctx,
    input  wire logic                 eng_wvalid,
    input  wire logic [31:0]          eng_wdata,
    output logic                      eng_wready,
    // Interrupts
    input  wire logic                 csc_irq,
    output logic                      page_copy_irq,
    output logic                      shared_irq
);
    if (CCS_NCH != 4) begin : g_chk
        $error("context layout serves exactly four channels");
    end

    ccs_state_t             st_r;
    ccs_mreq_t              mem_r;
    ccs_pkt_t               pkt_r;
    logic [31:0]            ptr_r [CCS_NCH];
    logic [CCS_NCH-1:0]     act_r;
    logic [1:0]             cur_r;
    logic [1:0]             last_r;
    logic [3:0]             idx_r;
    logic [9:0][31:0]       ctx_r;
    logic                   go_r;
    logic                   pc_irq_r;
    logic                   sh_irq_r;
    logic                   f_valid;
    logic [31:0]            f_data;

    // Round robin: search starts just after the last served channel
    function automatic logic [1:0] ccs_pick(input logic [3:0] act, input logic [1:0] last);
        logic [1:0] c;
        ccs_pick = last;
        for (int k = CCS_NCH; k >= 1; k--) begin
            c = 2'(last + 2'(k));
            if (act[c]) begin
                ccs_pick = c;
            end
        end
    endfunction

    wire        is_done  = (st_r == CCS_DONE);
    wire        cbc      = pkt_r.ctrl[CCS_CTL_CBC];
    wire        sha1     = pkt_r.ctrl[CCS_CTL_SHA1];
    wire        in_ciph  = (idx_r < CCS_CIPH_WORDS);
    wire        need_wr  = in_ciph ? cbc : sha1;
    wire        need_rd  = in_ciph ? cbc : (sha1 && !pkt_r.ctrl[CCS_CTL_HINIT]);
    wire        at_end   = (idx_r == CCS_IDX_END);
    wire        acked    = mem_r.req && mem_ack;
    wire        f_pop    = (st_r == CCS_DRAIN) && !at_end;
    wire [31:0] pkt_addr = ptr_r[cur_r] + {26'h0, idx_r, 2'b00};
    wire [31:0] ctx_addr = ccs_ctx_addr(ctx_base, cur_r, idx_r);
    wire        irq_ev   = is_done && pkt_r.ctrl[CCS_CTL_IRQ];

    assign chan_busy     = act_r;
    assign mem_o         = mem_r;
    assign eng_go        = go_r;
    assign eng_chan      = cur_r;
    assign eng_ctrl      = pkt_r.ctrl;
    assign eng_ctx       = ctx_r;
    assign page_copy_irq = pc_irq_r;
    assign shared_irq    = sh_irq_r;

    // Engine hands back the whole updated context; stalls when full
    ccs_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_valid  (eng_wvalid),
        .in_data   (eng_wdata),
        .in_ready  (eng_wready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (f_pop)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Channel activity and packet pointers; a start only lands on an idle one
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            act_r <= '0;
            for (int c = 0; c < CCS_NCH; c++) begin
                ptr_r[c] <= 32'h0;
            end
        end else begin
            for (int c = 0; c < CCS_NCH; c++) begin
                if (is_done && cur_r == 2'(c)) begin
                    ptr_r[c] <= pkt_r.next;
                    act_r[c] <= pkt_r.ctrl[CCS_CTL_CHAIN] && (pkt_r.next != 32'h0);
                end
                if (chan_start[c] && !act_r[c]) begin
                    ptr_r[c] <= chan_ptr;
                    act_r[c] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: fetch, reload, run, collect, save, complete
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r   <= CCS_IDLE;
            mem_r  <= '0;
            pkt_r  <= '0;
            cur_r  <= 2'h0;
            last_r <= CCS_TOP_CH;
            idx_r  <= 4'h0;
            ctx_r  <= '0;
            go_r   <= 1'b0;
        end else begin
            go_r <= 1'b0;
            case (st_r)
                CCS_IDLE: begin
                    if (|act_r) begin
                        cur_r <= ccs_pick(act_r, last_r);
                        idx_r <= CCS_IDX_NEXT;
                        st_r  <= CCS_FETCH;
                    end
                end
                CCS_FETCH: begin
                    if (!mem_r.req) begin
                        mem_r <= '{req: 1'b1, we: 1'b0, addr: pkt_addr, wdata: 32'h0};
                    end else if (mem_ack) begin
                        mem_r.req <= 1'b0;
                        if (idx_r == CCS_IDX_NEXT) begin
                            pkt_r.next <= mem_rdata;
                            idx_r      <= CCS_IDX_CTRL;
                        end else begin
                            pkt_r.ctrl <= mem_rdata;
                            idx_r      <= 4'h0;
                            st_r       <= CCS_RESTORE;
                        end
                    end
                end
                CCS_RESTORE: begin
                    // Entered only after the previous save was acknowledged
                    if (at_end) begin
                        go_r <= 1'b1;
                        st_r <= CCS_RUN;
                    end else if (!need_rd) begin
                        idx_r <= idx_r + 4'h1;
                    end else if (!mem_r.req) begin
                        mem_r <= '{req: 1'b1, we: 1'b0, addr: ctx_addr, wdata: 32'h0};
                    end else if (mem_ack) begin
                        mem_r.req    <= 1'b0;
                        ctx_r[idx_r] <= mem_rdata;
                        idx_r        <= idx_r + 4'h1;
                    end
                end
                CCS_RUN: begin
                    idx_r <= 4'h0;
                    st_r  <= CCS_DRAIN;
                end
                CCS_DRAIN: begin
                    if (at_end) begin
                        idx_r <= 4'h0;
                        st_r  <= CCS_SAVE;
                    end else if (f_valid) begin
                        ctx_r[idx_r] <= f_data;
                        idx_r        <= idx_r + 4'h1;
                    end
                end
                CCS_SAVE: begin
                    if (at_end) begin
                        st_r <= CCS_DONE;
                    end else if (!need_wr) begin
                        idx_r <= idx_r + 4'h1;
                    end else if (!mem_r.req) begin
                        mem_r <= '{req: 1'b1, we: 1'b1, addr: ctx_addr, wdata: ctx_r[idx_r]};
                    end else if (mem_ack) begin
                        mem_r.req <= 1'b0;
                        idx_r     <= idx_r + 4'h1;
                    end
                end
                default: begin
                    last_r <= cur_r;
                    st_r   <= CCS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Completion interrupts, one-cycle pulses; shared_irq also passes csc_irq for as long as it is held
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pc_irq_r <= 1'b0;
            sh_irq_r <= 1'b0;
        end else begin
            pc_irq_r <= irq_ev && (cur_r == 2'h0);
            sh_irq_r <= (irq_ev && (cur_r != 2'h0)) || csc_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_PTR_CHAIN: assert property (is_done |=> ptr_r[$past(cur_r)] == $past(pkt_r.next))
        else $error("pointer not chained");
    AST_IRQ_PRIV: assert property (pc_irq_r |-> $past(irq_ev) && $past(cur_r) == 2'h0)
        else $error("bad page-copy irq");
    AST_IRQ_SHARED: assert property (irq_ev && cur_r != 2'h0 |=> sh_irq_r && !pc_irq_r)
        else $error("shared irq missing");
    AST_RR_FAIR: assert property (st_r == CCS_IDLE && act_r[2'(last_r + 2'h1)]
        |=> cur_r == 2'($past(last_r) + 2'h1)) else $error("round robin skipped");
    AST_CTX_ADDR: assert property (mem_r.req && st_r != CCS_FETCH
        |-> mem_r.addr - ctx_base == {24'h0, 8'(8'(CCS_TOP_CH - cur_r) * CCS_CHAN_BYTES)}
            + {26'h0, idx_r, 2'b00} && mem_r.addr - ctx_base < {24'h0, CCS_CTX_BYTES})
        else $error("context address out of channel area");
    AST_SAVE_DONE: assert property (st_r == CCS_DRAIN && at_end |-> ##[1:40] is_done)
        else $error("save did not complete");
    AST_RELOAD: assert property (st_r == CCS_RESTORE && acked
        |=> ctx_r[$past(idx_r)] == $past(mem_rdata)) else $error("context not reloaded");
    AST_CIPH_WR: assert property (mem_r.req && mem_r.we && in_ciph |-> cbc)
        else $error("cipher context written without chained mode");
    AST_HASH_WR: assert property (mem_r.req && mem_r.we && !in_ciph |-> sha1
        && mem_r.addr - ctx_base >= {24'h0, CCS_HASH_OFS}) else $error("hash context written without SHA-1");
    AST_NO_OVERLAP: assert property (st_r == CCS_RESTORE |-> !(mem_r.req && mem_r.we))
        else $error("reload overlaps save");

    COV_CHAIN: cover property (is_done && pkt_r.ctrl[CCS_CTL_CHAIN] ##[1:200] st_r == CCS_FETCH);
    COV_IRQ0: cover property (pc_irq_r);
    COV_SWITCH: cover property (is_done && cur_r != last_r);
    COV_FULL: cover property (!eng_wready && st_r != CCS_DRAIN);
endmodule

// ---- hdl/ccs_pkg.sv ----
// Constants and carriers for the coprocessor channel context logic
package ccs_pkg;
    localparam int         CCS_NCH        = 4;
    localparam logic [1:0] CCS_TOP_CH     = 2'h3;
    localparam logic [3:0] CCS_CIPH_WORDS = 4'h4;
    localparam logic [3:0] CCS_IDX_END    = 4'hA;
    localparam logic [3:0] CCS_IDX_NEXT   = 4'h0;
    localparam logic [3:0] CCS_IDX_CTRL   = 4'h1;
    localparam logic [7:0] CCS_CTX_BYTES  = 8'hA0;
    localparam logic [7:0] CCS_CHAN_BYTES = 8'h28;
    localparam logic [7:0] CCS_HASH_OFS   = 8'h10;
    localparam int         CCS_CTL_IRQ    = 0;
    localparam int         CCS_CTL_CHAIN  = 1;
    localparam int         CCS_CTL_CBC    = 2;
    localparam int         CCS_CTL_SHA1   = 3;
    localparam int         CCS_CTL_HINIT  = 4;

    typedef enum logic [2:0] {
        CCS_IDLE    = 3'h0,
        CCS_FETCH   = 3'h1,
        CCS_RESTORE = 3'h3,
        CCS_RUN     = 3'h2,
        CCS_DRAIN   = 3'h6,
        CCS_SAVE    = 3'h7,
        CCS_DONE    = 3'h5
    } ccs_state_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ccs_mreq_t;

    typedef struct packed {
        logic [31:0] next;
        logic [31:0] ctrl;
    } ccs_pkt_t;

    // Channel 3 lowest, channel 0 highest; hash words follow cipher words
    function automatic logic [31:0] ccs_ctx_addr(input logic [31:0] base,
                                                 input logic [1:0]  ch,
                                                 input logic [3:0]  idx);
        logic [7:0] ofs;
        ofs = 8'(8'(CCS_TOP_CH - ch) * CCS_CHAN_BYTES);
        return base + {24'h0, ofs} + {26'h0, idx, 2'b00};
    endfunction
endpackage

// ---- verification/ccs_mem_model.sv ----
// System memory model holding work packets and the context buffer
`timescale 1ns/1ps
module ccs_mem_model
    import ccs_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Request side
    input  wire ccs_mreq_t  mem_req,
    input  wire logic [3:0] wait_cycles,
    output logic            mem_ack,
    output logic [31:0]     mem_rdata
);
    logic [31:0] mem [256];
    logic [3:0]  wait_r;
    wire  [7:0]  word_idx = mem_req.addr[9:2];

    ////////////////////////////////////////////////////////////////////////////
    // Buffer lives wherever the bench points the base; read data inverts every cycle between acks
    // Plain always: the bench preloads the array hierarchically
    always @(posedge clk) begin
        if (!reset_n) begin
            mem_ack <= 1'b0;
            wait_r  <= 4'h0;
        end else if (mem_req.req && !mem_ack && wait_r == wait_cycles) begin
            mem_ack <= 1'b1;
            wait_r  <= 4'h0;
            if (mem_req.we) begin
                mem[word_idx] <= mem_req.wdata;
            end else begin
                mem_rdata <= mem[word_idx];
            end
        end else begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req.req && !mem_ack) begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule

// ---- verification/test_crypto_coprocessor_context_switch.sv ----
// Self-checking bench for the channel context logic
`timescale 1ns/1ps
module test_crypto_coprocessor_context_switch
    import ccs_pkg::*;
;
    logic             clk, reset_n, mem_ack, eng_go, eng_wvalid, eng_wready;
    logic             csc_irq, page_copy_irq, shared_irq;
    logic [31:0]      ctx_base, chan_ptr, mem_rdata, eng_ctrl, eng_wdata, got_ctrl;
    logic [3:0]       chan_start, chan_busy, mem_wait, served;
    logic [1:0]       eng_chan, got_chan;
    logic [9:0][31:0] eng_ctx, got_ctx;
    ccs_mreq_t        mem_o;
    int               miscompares, checked, pc_cnt, sh_cnt, i, j;

    ccs_ctx_switch #(.FIFO_DEPTH(8)) ccs_ctx_switch_inst (.clk(clk), .reset_n(reset_n),
        .ctx_base(ctx_base), .chan_start(chan_start), .chan_ptr(chan_ptr), .chan_busy(chan_busy),
        .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .eng_go(eng_go),
        .eng_chan(eng_chan), .eng_ctrl(eng_ctrl), .eng_ctx(eng_ctx), .eng_wvalid(eng_wvalid),
        .eng_wdata(eng_wdata), .eng_wready(eng_wready), .csc_irq(csc_irq),
        .page_copy_irq(page_copy_irq), .shared_irq(shared_irq));
    ccs_mem_model ccs_mem_model_inst (.clk(clk), .reset_n(reset_n), .mem_req(mem_o),
        .wait_cycles(mem_wait), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [31:0] eword(input logic [1:0] ch, input logic [3:0] pkt, input int k);
        return {16'hC0DE, 6'h00, ch, pkt, 4'(k)};
    endfunction
    // Word index of context word i of a channel, base 0x200
    function automatic int cidx(input int ch, input int i);
        return 128 + (3 - ch) * 10 + i;
    endfunction
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic start_chan(input logic [3:0] mask, input logic [31:0] ptr);
        @(negedge clk);
        chan_start = mask;
        chan_ptr   = ptr;
        @(negedge clk);
        chan_start = 4'h0;
    endtask
    // Engine stand-in: takes one go, returns ten words through valid/ready
    task automatic serve(input logic [3:0] pkt);
        int   n;
        int   k;
        logic acc;
        n   = 0;
        k   = 0;
        acc = 1'b0;
        while (eng_go !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk("eng_go", 32'h1, eng_go);
        got_chan = eng_chan;
        got_ctrl = eng_ctrl;
        got_ctx  = eng_ctx;
        served[eng_chan] = 1'b1;
        while (k < 10 && n < 3000) begin
            @(negedge clk);
            n++;
            if (eng_wvalid && acc) k++;
            eng_wvalid = (k < 10);
            eng_wdata  = eword(got_chan, pkt, k);
            acc        = eng_wready;
        end
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (chan_busy !== 4'h0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk("chan_busy", 32'h0, chan_busy);
        // Completion pulse follows the done cycle; let the counters see it
        repeat (2) @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        chk("chan_busy after reset", 32'h0, chan_busy);
        chk("mem req after reset", 32'h0, mem_o.req);
        chk("irq after reset", 32'h0, {page_copy_irq, shared_irq, eng_go});
    endtask
    task automatic test_single_ch0();
        ccs_mem_model_inst.mem[4] = 32'h0;
        ccs_mem_model_inst.mem[5] = 32'hD;
        start_chan(4'h1, 32'h10);
        serve(4'h1);
        chk("eng_chan", 32'h0, got_chan);
        chk("hash reload", 32'h5A5A5A5A, got_ctx[4]);
        wait_idle();
        for (i = 0; i < 10; i++) chk("ch0 saved word", eword(0, 1, i), ccs_mem_model_inst.mem[cidx(0, i)]);
        chk("page copy count", 32'h1, pc_cnt);
        chk("shared count", 32'h0, sh_cnt);
    endtask
    task automatic test_chain_ch2();
        mem_wait = 4'h3;
        ccs_mem_model_inst.mem[8]  = 32'h30;
        ccs_mem_model_inst.mem[9]  = 32'h6;
        ccs_mem_model_inst.mem[12] = 32'h0;
        ccs_mem_model_inst.mem[13] = 32'h5;
        start_chan(4'h4, 32'h20);
        serve(4'h1);
        serve(4'h2);
        chk("chained ctrl", 32'h5, got_ctrl);
        for (i = 0; i < 4; i++) chk("cipher resumed", eword(2, 1, i), got_ctx[i]);
        wait_idle();
        for (i = 0; i < 4; i++) chk("ch2 cipher saved", eword(2, 2, i), ccs_mem_model_inst.mem[cidx(2, i)]);
        for (i = 4; i < 10; i++) chk("ch2 hash kept", 32'h5A5A5A5A, ccs_mem_model_inst.mem[cidx(2, i)]);
        chk("shared count", 32'h1, sh_cnt);
        chk("page copy count", 32'h1, pc_cnt);
    endtask
    task automatic test_all_channels();
        mem_wait = 4'h0;
        served   = 4'h0;
        ccs_mem_model_inst.mem[16] = 32'h0;
        ccs_mem_model_inst.mem[17] = 32'h9;
        start_chan(4'hF, 32'h40);
        for (j = 0; j < 4; j++) serve(4'h3);
        chk("channels served", 32'hF, served);
        wait_idle();
        for (j = 0; j < 4; j++) begin
            for (i = 4; i < 10; i++) chk("hash saved", eword(j, 3, i), ccs_mem_model_inst.mem[cidx(j, i)]);
        end
        chk("ch1 cipher kept", 32'h5A5A5A5A, ccs_mem_model_inst.mem[cidx(1, 0)]);
        chk("page copy count", 32'h2, pc_cnt);
        chk("shared count", 32'h4, sh_cnt);
    endtask
    task automatic test_csc();
        @(negedge clk);
        csc_irq = 1'b1;
        @(negedge clk);
        csc_irq = 1'b0;
        chk("shared from converter", 32'h1, shared_irq);
        chk("page copy quiet", 32'h0, page_copy_irq);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Count mid-cycle, where the one-cycle pulses stand settled
    always @(negedge clk) begin
        if (page_copy_irq === 1'b1) pc_cnt++;
        if (shared_irq === 1'b1) sh_cnt++;
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {reset_n, chan_start, chan_ptr, eng_wvalid, eng_wdata, csc_irq, mem_wait, served} = '0;
        {miscompares, checked, pc_cnt, sh_cnt} = '0;
        ctx_base = 32'h200;
        for (i = 0; i < 256; i++) ccs_mem_model_inst.mem[i] = 32'h5A5A5A5A;
        repeat (3) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        test_reset();
        test_single_ch0();
        test_chain_ch2();
        test_all_channels();
        test_csc();
        final_report();
    end
    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        miscompares++;
        final_report();
    end
endmodule
